// ===== rtl/selfprog_device.sv
// Operation
// - boot reset fuse picks application or boot vector
// - fuses are inputs only, never written here
// - hardware boot pin input, sampled at reset release
// - enabled and pin low selects boot vector
// - boot enable unprogrammed ignores the pin
// - z pointer splits into word and page fields
// - target page latched when operation starts
// - load-program reads bytes using byte select bit
// - erase pattern plus store within four cycles
// - erase halts core only in halting region
// - load pattern stores data word at word field
// - buffer cleared after write, read-enable, reset
// - core writes each buffer word once per erase
// - data eeprom write discards loaded buffer words
// - write pattern plus store programs latched page
// - write halts core only in halting region
// - interrupt requested while enable bit clear
// - core erases same page before writing it
// - loading allowed before or after page erase
// - buffer words load in any order
// - boot region writable while lock bit unprogrammed
// - command bits auto-clear after four idle cycles
// - busy flag holds until read-enable after programming
`default_nettype none
module selfprog_device
	import selfprog_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	selfprog_if.device bus,
	input wire logic boot_reset_select_fuse,
	input wire logic hardware_boot_enable_fuse,
	input wire logic hardware_boot_pin_in,
	output logic hardware_boot_pin_out,
	output logic hardware_boot_pin_oe,
	input wire logic boot_lock_bit11,
	input wire logic eeprom_wr,
	output logic [Z_W-1:0] reset_vector,
	output logic boot_sampled,
	output logic flash_erase_start,
	output logic flash_write_start,
	output logic [PAGE_W-1:0] flash_page,
	input wire logic flash_done,
	input wire logic [PAGE_WORDS_W-1:0] flash_buf_idx,
	output logic [WORD_W-1:0] flash_buf_data,
	output logic [FLASH_WORD_ADDR_W-1:0] flash_rd_addr,
	input wire logic [WORD_W-1:0] flash_rd_word
);
	// ========================================
	// state and storage
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_ARMED = 2'b01,
		DEV_BUSY = 2'b11
	} dev_state_e;

	dev_state_e state, next_state;
	logic [5:0] cmd, next_cmd;
	logic irq_en, next_irq_en;
	logic region_busy, next_region_busy;
	logic [2:0] arm_cnt, next_arm_cnt;
	logic busy_write, next_busy_write;
	logic halt, next_halt;
	logic [PAGE_W-1:0] page, next_page;
	logic [WORD_W-1:0] buffer [PAGE_WORDS];
	logic [WORD_W-1:0] next_buffer [PAGE_WORDS];
	logic erase_pulse, next_erase_pulse;
	logic write_pulse, next_write_pulse;
	logic lpm_pend, next_lpm_pend;
	logic byte_sel, next_byte_sel;
	logic [FLASH_WORD_ADDR_W-1:0] rd_addr, next_rd_addr;
	logic [7:0] lpm_byte, next_lpm_byte;
	logic boot_done, next_boot_done;
	logic [Z_W-1:0] vector, next_vector;
	logic [7:0] csr_view;
	logic irq_out;
	logic [WORD_W-1:0] buf_out;

	// page field of a z pointer value
	function automatic logic [PAGE_W-1:0] page_of(input logic [Z_W-1:0] z);
		page_of = z[Z_W-1:PAGE_FIELD_LSB];
	endfunction : page_of

	// word field of a z pointer value
	function automatic logic [PAGE_WORDS_W-1:0] word_of(input logic [Z_W-1:0] z);
		word_of = z[PAGE_FIELD_LSB-1:WORD_FIELD_LSB];
	endfunction : word_of

	// ========================================
	// command sequencing, buffer and status
	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_irq_en = irq_en;
		next_region_busy = region_busy;
		next_arm_cnt = arm_cnt;
		next_busy_write = busy_write;
		next_halt = halt;
		next_page = page;
		next_buffer = buffer;
		next_erase_pulse = 1'b0;
		next_write_pulse = 1'b0;
		case (state)
			DEV_IDLE, DEV_ARMED: begin
				if (bus.csr_wr) begin
					// a fresh write restarts the four cycle window
					next_irq_en = bus.csr_wdata[CSR_IRQ_EN_BIT];
					if (bus.csr_wdata[5:0] == CMD_RRE) begin
						next_cmd = 6'h00;
						next_state = DEV_IDLE;
						next_region_busy = 1'b0;
						for (int i = 0; i < PAGE_WORDS; i++) begin
							next_buffer[i] = BUFFER_ERASED;
						end
					end else if (bus.csr_wdata[CSR_ENABLE_BIT]) begin
						next_cmd = bus.csr_wdata[5:0];
						next_arm_cnt = ARM_CYCLES;
						next_state = DEV_ARMED;
					end else begin
						next_cmd = 6'h00;
						next_state = DEV_IDLE;
					end
				end else if (state == DEV_ARMED && bus.spm_strobe) begin
					next_cmd = 6'h00;
					next_state = DEV_IDLE;
					case (cmd)
						CMD_LOAD: begin
							next_buffer[word_of(bus.z_ptr)] = bus.data_word;
						end
						CMD_ERASE, CMD_WRITE: begin
							// a programmed upper lock bit refuses boot region targets
							if (boot_lock_bit11 || page_of(bus.z_ptr) < BOOT_FIRST_PAGE) begin
								next_page = page_of(bus.z_ptr);
								next_busy_write = (cmd == CMD_WRITE);
								next_erase_pulse = (cmd == CMD_ERASE);
								next_write_pulse = (cmd == CMD_WRITE);
								next_halt = (page_of(bus.z_ptr) >= HALTING_FIRST_PAGE);
								if (page_of(bus.z_ptr) < HALTING_FIRST_PAGE) begin
									next_region_busy = 1'b1;
								end
								next_cmd = cmd;
								next_state = DEV_BUSY;
							end
						end
						default: begin
							next_cmd = 6'h00;
						end
					endcase
				end else if (state == DEV_ARMED) begin
					next_arm_cnt = arm_cnt - 3'h1;
					if (arm_cnt == 3'h1) begin
						next_cmd = 6'h00;
						next_state = DEV_IDLE;
					end
				end
			end
			DEV_BUSY: begin
				// control writes are ignored while the flash is busy
				if (flash_done) begin
					next_cmd = 6'h00;
					next_halt = 1'b0;
					next_state = DEV_IDLE;
					if (busy_write) begin
						for (int i = 0; i < PAGE_WORDS; i++) begin
							next_buffer[i] = BUFFER_ERASED;
						end
					end
				end
			end
			default: begin
				next_state = DEV_IDLE;
				next_cmd = 6'h00;
			end
		endcase
		// an eeprom write loses any partly loaded page
		if (eeprom_wr) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				next_buffer[i] = BUFFER_ERASED;
			end
		end
		csr_view = {next_irq_en, next_region_busy, next_cmd};
		irq_out = next_irq_en && !next_cmd[CSR_ENABLE_BIT];
		buf_out = next_buffer[flash_buf_idx];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= DEV_IDLE;
			cmd <= 6'h00;
			irq_en <= 1'b0;
			region_busy <= 1'b0;
			arm_cnt <= 3'h0;
			busy_write <= 1'b0;
			halt <= 1'b0;
			page <= '0;
			for (int i = 0; i < PAGE_WORDS; i++) begin
				buffer[i] <= BUFFER_ERASED;
			end
			erase_pulse <= 1'b0;
			write_pulse <= 1'b0;
			bus.csr_rdata <= 8'h00;
			bus.spm_irq <= 1'b0;
			bus.cpu_halt <= 1'b0;
			flash_buf_data <= BUFFER_ERASED;
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			irq_en <= next_irq_en;
			region_busy <= next_region_busy;
			arm_cnt <= next_arm_cnt;
			busy_write <= next_busy_write;
			halt <= next_halt;
			page <= next_page;
			buffer <= next_buffer;
			erase_pulse <= next_erase_pulse;
			write_pulse <= next_write_pulse;
			bus.csr_rdata <= csr_view;
			bus.spm_irq <= irq_out;
			bus.cpu_halt <= next_halt;
			flash_buf_data <= buf_out;
		end
	end

	assign flash_erase_start = erase_pulse;
	assign flash_write_start = write_pulse;
	assign flash_page = page;

	// ========================================
	// byte reads of program memory
	always_comb begin
		next_lpm_pend = bus.lpm_strobe;
		next_rd_addr = rd_addr;
		next_byte_sel = byte_sel;
		next_lpm_byte = lpm_byte;
		if (bus.lpm_strobe) begin
			next_rd_addr = bus.z_ptr[Z_W-1:1];
			next_byte_sel = bus.z_ptr[0];
		end
		if (lpm_pend) begin
			next_lpm_byte = byte_sel ? flash_rd_word[15:8] : flash_rd_word[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lpm_pend <= 1'b0;
			rd_addr <= '0;
			byte_sel <= 1'b0;
			lpm_byte <= 8'h00;
			bus.lpm_valid <= 1'b0;
		end else begin
			lpm_pend <= next_lpm_pend;
			rd_addr <= next_rd_addr;
			byte_sel <= next_byte_sel;
			lpm_byte <= next_lpm_byte;
			bus.lpm_valid <= lpm_pend;
		end
	end

	assign flash_rd_addr = rd_addr;
	assign bus.lpm_data = lpm_byte;

	// ========================================
	// reset vector; fuses arrive as pins so nothing here can alter them
	always_comb begin
		next_boot_done = 1'b1;
		next_vector = vector;
		if (!boot_done) begin
			// first edge after release stands in for the reset rising edge
			if (!boot_reset_select_fuse) begin
				next_vector = BOOT_RESET_ADDR;
			end else if (!hardware_boot_enable_fuse && !hardware_boot_pin_in) begin
				next_vector = BOOT_RESET_ADDR;
			end else begin
				next_vector = APP_RESET_ADDR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_done <= 1'b0;
			vector <= APP_RESET_ADDR;
			hardware_boot_pin_out <= 1'b0;
			hardware_boot_pin_oe <= 1'b0;
		end else begin
			boot_done <= next_boot_done;
			vector <= next_vector;
			hardware_boot_pin_out <= 1'b0;
			hardware_boot_pin_oe <= 1'b0;
		end
	end

	assign reset_vector = vector;
	assign boot_sampled = boot_done;
endmodule : selfprog_device
`default_nettype wire

// ===== common/selfprog_pkg.sv
`default_nettype none
package selfprog_pkg;
	// ========================================
	// address layout of the z pointer
	localparam int Z_W = 16;
	localparam int WORD_W = 16;
	localparam int PAGE_WORDS_W = 6;
	localparam int PAGE_W = 9;
	localparam int FLASH_WORD_ADDR_W = 15;
	localparam int WORD_FIELD_LSB = 1;
	localparam int PAGE_FIELD_LSB = 7;
	localparam int PAGE_WORDS = 64;
	localparam logic [WORD_W-1:0] BUFFER_ERASED = 16'hFFFF;

	// ========================================
	// memory regions and reset vectors
	localparam logic [Z_W-1:0] APP_RESET_ADDR = 16'h0000;
	localparam logic [Z_W-1:0] BOOT_RESET_ADDR = 16'h3800;
	localparam logic [PAGE_W-1:0] HALTING_FIRST_PAGE = 9'h0C0;
	localparam logic [PAGE_W-1:0] BOOT_FIRST_PAGE = 9'h0E0;

	// ========================================
	// selfprog_control_status bit positions and command patterns
	localparam int CSR_ENABLE_BIT = 0;
	localparam int CSR_RRE_BIT = 4;
	localparam int CSR_BUSY_BIT = 6;
	localparam int CSR_IRQ_EN_BIT = 7;
	localparam logic [5:0] CMD_LOAD = 6'h01;
	localparam logic [5:0] CMD_ERASE = 6'h03;
	localparam logic [5:0] CMD_WRITE = 6'h05;
	localparam logic [5:0] CMD_RRE = 6'h11;
	localparam logic [2:0] ARM_CYCLES = 3'h4;

	// ========================================
	// controller registers on axi4-lite
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ZPTR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_LPM = 8'h10;
	localparam int CMD_IRQ_EN_BIT = 3;
	localparam logic [2:0] OP_LOAD = 3'h0;
	localparam logic [2:0] OP_ERASE = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_RRE = 3'h3;
	localparam logic [2:0] OP_LPM = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : selfprog_pkg
`default_nettype wire

// ===== common/selfprog_if.sv
`default_nettype none
interface selfprog_if;
	import selfprog_pkg::*;
	logic csr_wr;
	logic [7:0] csr_wdata;
	logic [7:0] csr_rdata;
	logic spm_strobe;
	logic lpm_strobe;
	logic [Z_W-1:0] z_ptr;
	logic [WORD_W-1:0] data_word;
	logic [7:0] lpm_data;
	logic lpm_valid;
	logic cpu_halt;
	logic spm_irq;

	modport device (input csr_wr, csr_wdata, spm_strobe, lpm_strobe, z_ptr, data_word,
		output csr_rdata, lpm_data, lpm_valid, cpu_halt, spm_irq);
	modport core (output csr_wr, csr_wdata, spm_strobe, lpm_strobe, z_ptr, data_word,
		input csr_rdata, lpm_data, lpm_valid, cpu_halt, spm_irq);
endinterface : selfprog_if
`default_nettype wire

// ===== rtl/selfprog_core_ctrl.sv
`default_nettype none
module selfprog_core_ctrl
	import selfprog_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	selfprog_if.core bus,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ========================================
	// sequencer that plays the core's part
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_SETCSR = 2'b01,
		SEQ_ISSUE = 2'b11,
		SEQ_WAIT = 2'b10
	} seq_state_e;

	seq_state_e state, next_state;
	logic [2:0] op, next_op;
	logic irq_en, next_irq_en;
	logic [Z_W-1:0] zptr, next_zptr;
	logic [WORD_W-1:0] data, next_data;
	logic [7:0] lpm_res, next_lpm_res;
	logic csr_wr, next_csr_wr;
	logic store_program_instruction, next_spm;
	logic load_program_instruction, next_lpm;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic do_write;

	// command pattern for each operation; the busy bit is read-only
	function automatic logic [7:0] pattern(input logic [2:0] o, input logic ie);
		case (o)
			OP_LOAD: pattern = {ie, 1'b0, CMD_LOAD};
			OP_ERASE: pattern = {ie, 1'b0, CMD_ERASE};
			OP_WRITE: pattern = {ie, 1'b0, CMD_WRITE};
			OP_RRE: pattern = {ie, 1'b0, CMD_RRE};
			default: pattern = {ie, 7'h00};
		endcase
	endfunction : pattern

	// ========================================
	// bus slave and sequencing
	always_comb begin
		next_state = state;
		next_op = op;
		next_irq_en = irq_en;
		next_zptr = zptr;
		next_data = data;
		next_lpm_res = lpm_res;
		next_csr_wr = 1'b0;
		next_spm = 1'b0;
		next_lpm = 1'b0;
		next_aw_held = aw_held || s_axi_awvalid;
		next_w_held = w_held || s_axi_wvalid;
		next_aw_addr = (s_axi_awvalid && !aw_held) ? s_axi_awaddr : aw_addr;
		next_w_data = (s_axi_wvalid && !w_held) ? s_axi_wdata : w_data;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		next_rvalid = rvalid && !s_axi_rready;
		next_rdata = rdata;
		next_rresp = rresp;
		do_write = aw_held && w_held && !bvalid;
		// address and data may come in either order; act once both are held
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			case (aw_addr)
				REG_CMD: begin
					// a command while one is running is dropped, not queued
					if (state == SEQ_IDLE && w_data[0]) begin
						next_op = w_data[6:4];
						next_irq_en = w_data[CMD_IRQ_EN_BIT];
						next_state = (w_data[6:4] == OP_LPM) ? SEQ_ISSUE : SEQ_SETCSR;
					end
				end
				REG_ZPTR: next_zptr = w_data[Z_W-1:0];
				REG_DATA: next_data = w_data[WORD_W-1:0];
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			case (s_axi_araddr)
				REG_CMD: next_rdata = {25'h0, op, irq_en, 2'h0, (state != SEQ_IDLE)};
				REG_ZPTR: next_rdata = {16'h0, zptr};
				REG_DATA: next_rdata = {16'h0, data};
				REG_STATUS: next_rdata = {21'h0, bus.spm_irq, bus.cpu_halt, (state != SEQ_IDLE), bus.csr_rdata};
				REG_LPM: next_rdata = {24'h0, lpm_res};
				default: begin
					next_rdata = 32'h0;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		case (state)
			SEQ_IDLE: begin
				if (next_state == SEQ_SETCSR) begin
					next_csr_wr = 1'b1;
				end else if (next_state == SEQ_ISSUE) begin
					next_lpm = 1'b1;
					next_state = SEQ_WAIT;
				end
			end
			SEQ_SETCSR: begin
				// store follows one cycle later, well inside four cycles
				next_spm = (op != OP_RRE);
				next_state = (op == OP_RRE) ? SEQ_WAIT : SEQ_ISSUE;
			end
			SEQ_ISSUE: next_state = SEQ_WAIT;
			SEQ_WAIT: begin
				if (op == OP_LPM) begin
					if (bus.lpm_valid) begin
						next_lpm_res = bus.lpm_data;
						next_state = SEQ_IDLE;
					end
				end else if (!bus.csr_rdata[CSR_ENABLE_BIT]) begin
					next_state = SEQ_IDLE;
				end
			end
			default: next_state = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= SEQ_IDLE;
			op <= OP_LOAD;
			irq_en <= 1'b0;
			zptr <= '0;
			data <= '0;
			lpm_res <= 8'h00;
			csr_wr <= 1'b0;
			store_program_instruction <= 1'b0;
			load_program_instruction <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else begin
			state <= next_state;
			op <= next_op;
			irq_en <= next_irq_en;
			zptr <= next_zptr;
			data <= next_data;
			lpm_res <= next_lpm_res;
			csr_wr <= next_csr_wr;
			store_program_instruction <= next_spm;
			load_program_instruction <= next_lpm;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign bus.csr_wr = csr_wr;
	assign bus.csr_wdata = pattern(op, irq_en);
	assign bus.spm_strobe = store_program_instruction;
	assign bus.lpm_strobe = load_program_instruction;
	assign bus.z_ptr = zptr;
	assign bus.data_word = data;
endmodule : selfprog_core_ctrl
`default_nettype wire

// ===== verif/selfprog_monitor.sv
`default_nettype none
module selfprog_monitor
	import selfprog_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic csr_wr,
	input wire logic [7:0] csr_wdata,
	input wire logic [7:0] csr_rdata,
	input wire logic spm_strobe,
	input wire logic lpm_strobe,
	input wire logic [Z_W-1:0] z_ptr,
	input wire logic [WORD_W-1:0] data_word,
	input wire logic [7:0] lpm_data,
	input wire logic lpm_valid,
	input wire logic cpu_halt,
	input wire logic spm_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ========================================
	// launch decode: page under the pointer and a store that starts erase or write
	wire [PAGE_W-1:0] pg = z_ptr[Z_W-1:PAGE_FIELD_LSB];
	wire [5:0] cmd = csr_rdata[5:0];
	wire prog = spm_strobe && (cmd == CMD_ERASE || cmd == CMD_WRITE);
	// ========================================
	// link assertions; boot-region pages left out since the lock bit is not visible here
	a_arm_on_write: assert property (csr_wr && csr_wdata[0] && !csr_rdata[0] && csr_wdata[5:0] != CMD_RRE
		&& pg < BOOT_FIRST_PAGE |=> cmd == $past(csr_wdata[5:0]) && csr_rdata[7] == $past(csr_wdata[7]))
		else $error("command pattern not armed");
	a_busy_holds: assert property (csr_rdata[6] && !(csr_wr && csr_wdata[5:0] == CMD_RRE) |=> csr_rdata[6])
		else $error("region busy flag dropped early");
	a_halt_region: assert property (prog && pg >= HALTING_FIRST_PAGE && pg < BOOT_FIRST_PAGE |-> ##[1:2] cpu_halt)
		else $error("halting page did not halt core");
	a_concurrent_free: assert property (prog && pg < HALTING_FIRST_PAGE |=> csr_rdata[6] && !cpu_halt)
		else $error("concurrent page blocked core");
	a_halt_enable: assert property (cpu_halt |-> csr_rdata[0])
		else $error("enable bit low while halted");
	a_halt_cause: assert property ($rose(cpu_halt) |-> $past(spm_strobe) || $past(spm_strobe, 2))
		else $error("halt without store");
	a_irq_level: assert property ((csr_rdata[7] && !csr_rdata[0]) [*2] |-> spm_irq)
		else $error("interrupt missing");
	a_irq_quiet: assert property ((!csr_rdata[7] || csr_rdata[0]) [*2] |-> !spm_irq)
		else $error("interrupt raised wrongly");
	a_lpm_answer: assert property (lpm_strobe |-> ##[1:2] lpm_valid)
		else $error("load-program read not answered");
	a_load_quick: assert property (spm_strobe && cmd == CMD_LOAD |-> ##[1:2] !csr_rdata[0])
		else $error("load left enable bit set");
endmodule : selfprog_monitor
`default_nettype wire

// ===== verif/tb_flash_self_programming_boot_entry.sv
`default_nettype none
module tb_flash_self_programming_boot_entry
	import selfprog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, eeprom_wr = 1'b0, flash_done = 1'b0, boot_lock_bit11 = 1'b1;
	logic boot_reset_select_fuse = 1'b1, hardware_boot_enable_fuse = 1'b1, hardware_boot_pin_in = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, v;
	logic [PAGE_WORDS_W-1:0] flash_buf_idx = '0;
	logic awready, wready, bvalid, arready, rvalid, pin_oe, pin_out, erase_start, write_start, boot_sampled;
	logic [1:0] bresp, rresp, resp;
	logic [Z_W-1:0] reset_vector;
	logic [PAGE_W-1:0] flash_page, last_page;
	logic [WORD_W-1:0] flash_buf_data, flash_rd_word;
	logic [FLASH_WORD_ADDR_W-1:0] flash_rd_addr;
	logic [2:0] fcnt = '0;
	int starts = 0, halts = 0, mismatches = 0, num_checks = 0;
	selfprog_if sp();
	selfprog_device selfprog_device_i (.aclk(aclk), .aresetn(aresetn), .bus(sp),
		.boot_reset_select_fuse(boot_reset_select_fuse), .hardware_boot_enable_fuse(hardware_boot_enable_fuse),
		.hardware_boot_pin_in(hardware_boot_pin_in), .hardware_boot_pin_out(pin_out), .hardware_boot_pin_oe(pin_oe),
		.boot_lock_bit11(boot_lock_bit11), .eeprom_wr(eeprom_wr), .reset_vector(reset_vector),
		.boot_sampled(boot_sampled), .flash_erase_start(erase_start), .flash_write_start(write_start),
		.flash_page(flash_page), .flash_done(flash_done), .flash_buf_idx(flash_buf_idx),
		.flash_buf_data(flash_buf_data), .flash_rd_addr(flash_rd_addr), .flash_rd_word(flash_rd_word));
	selfprog_core_ctrl selfprog_core_ctrl_i (.aclk(aclk), .aresetn(aresetn), .bus(sp),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	selfprog_monitor selfprog_monitor_i (.aclk(aclk), .aresetn(aresetn), .csr_wr(sp.csr_wr),
		.csr_wdata(sp.csr_wdata), .csr_rdata(sp.csr_rdata), .spm_strobe(sp.spm_strobe),
		.lpm_strobe(sp.lpm_strobe), .z_ptr(sp.z_ptr), .data_word(sp.data_word), .lpm_data(sp.lpm_data),
		.lpm_valid(sp.lpm_valid), .cpu_halt(sp.cpu_halt), .spm_irq(sp.spm_irq));
	// ========================================
	// clock and flash macro stand-in; rom contents scrambled so byte swaps show up
	always #10 aclk = ~aclk;
	assign flash_rd_word = {1'b0, flash_rd_addr} ^ 16'h5A3C;
	always @(posedge aclk) begin
		flash_done <= (fcnt == 3'h1);
		fcnt <= (erase_start || write_start) ? 3'h5 : ((fcnt != 3'h0) ? fcnt - 3'h1 : fcnt);
		if (erase_start || write_start) starts <= starts + 1;
		if (flash_done) last_page <= flash_page;
		if (sp.cpu_halt) halts <= halts + 1;
	end
	// ========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge aclk);
		while (bready) begin
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk(32'(bresp), 32'(e));
			end
			@(posedge aclk);
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (rready) begin
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				d = rdata;
				resp = rresp;
			end
			@(posedge aclk);
		end
	endtask : rd
	// pointer is scribbled over after erase or write starts, so a live pointer would show
	task automatic run(input logic [2:0] op, input logic [15:0] z, input logic [15:0] d, input logic irq);
		wr(REG_ZPTR, 32'(z), RESP_OKAY);
		wr(REG_DATA, 32'(d), RESP_OKAY);
		wr(REG_CMD, {25'h0, op, irq, 3'h1}, RESP_OKAY);
		if (op == OP_ERASE || op == OP_WRITE) wr(REG_ZPTR, 32'h0000FFFF, RESP_OKAY);
		do rd(REG_STATUS, v); while (v[8] === 1'b1);
	endtask : run
	task automatic bchk(input logic [5:0] i, input logic [15:0] e);
		flash_buf_idx <= i;
		repeat (2) @(posedge aclk);
		chk(32'(flash_buf_data), 32'(e));
	endtask : bchk
	// ========================================
	// scenarios
	task automatic t_boot;
		logic [2:0] f;
		logic [15:0] e;
		for (int i = 0; i < 8; i++) begin
			f = 3'(i);
			e = (!f[2] || (!f[1] && !f[0])) ? BOOT_RESET_ADDR : APP_RESET_ADDR;
			aresetn <= 1'b0;
			{boot_reset_select_fuse, hardware_boot_enable_fuse, hardware_boot_pin_in} <= f;
			repeat (4) @(posedge aclk);
			aresetn <= 1'b1;
			repeat (2) @(posedge aclk);
			hardware_boot_pin_in <= ~f[0];
			repeat (2) @(posedge aclk);
			chk(32'(reset_vector), 32'(e));
			chk(32'({boot_sampled, pin_oe, pin_out}), 32'h4);
			bchk(6'(i), BUFFER_ERASED);
		end
	endtask : t_boot
	task automatic t_page;
		int s;
		run(OP_LOAD, {9'h010, 6'd5, 1'b0}, 16'hA501, 1'b0);
		run(OP_LOAD, {9'h1FF, 6'd2, 1'b1}, 16'h5A02, 1'b0);
		s = starts;
		run(OP_ERASE, {9'h010, 6'h2A, 1'b1}, 16'hDEAD, 1'b0);
		chk(32'(starts), 32'(s + 1));
		chk(32'(last_page), 32'h010);
		bchk(6'd5, 16'hA501);
		bchk(6'd2, 16'h5A02);
		bchk(6'd3, BUFFER_ERASED);
		run(OP_WRITE, {9'h010, 7'h0}, 16'h0, 1'b0);
		chk(32'({last_page, 4'(starts - s)}), {19'h0, 9'h010, 4'h2});
		bchk(6'd5, BUFFER_ERASED);
		rd(REG_STATUS, v);
		chk(32'(v[6]), 32'h1);
		run(OP_RRE, 16'h0, 16'h0, 1'b0);
		rd(REG_STATUS, v);
		chk(32'(v[6]), 32'h0);
	endtask : t_page
	task automatic t_halt;
		int h;
		h = halts;
		run(OP_ERASE, {9'h0C5, 7'h0}, 16'h0, 1'b0);
		chk(32'(halts > h), 32'h1);
		run(OP_LOAD, {9'h0C5, 6'd0, 1'b0}, 16'h1234, 1'b0);
		bchk(6'd0, 16'h1234);
		h = halts;
		run(OP_WRITE, {9'h0C5, 7'h0}, 16'h0, 1'b0);
		chk(32'(halts > h), 32'h1);
	endtask : t_halt
	task automatic t_discard;
		run(OP_LOAD, {9'h020, 6'd7, 1'b0}, 16'hC3C3, 1'b0);
		eeprom_wr <= 1'b1;
		@(posedge aclk);
		eeprom_wr <= 1'b0;
		bchk(6'd7, BUFFER_ERASED);
		run(OP_LOAD, {9'h020, 6'd9, 1'b0}, 16'h3C3C, 1'b0);
		bchk(6'd9, 16'h3C3C);
		run(OP_RRE, 16'h0, 16'h0, 1'b0);
		bchk(6'd9, BUFFER_ERASED);
		// a loaded word must not survive a system reset
		run(OP_LOAD, {9'h020, 6'd3, 1'b0}, 16'h7777, 1'b0);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		bchk(6'd3, BUFFER_ERASED);
	endtask : t_discard
	task automatic t_lock;
		int s;
		s = starts;
		boot_lock_bit11 <= 1'b0;
		run(OP_ERASE, {9'h0E2, 7'h0}, 16'h0, 1'b0);
		chk(32'(starts), 32'(s));
		boot_lock_bit11 <= 1'b1;
		run(OP_ERASE, {9'h0E2, 7'h0}, 16'h0, 1'b0);
		chk(32'({last_page, 4'(starts - s)}), {19'h0, 9'h0E2, 4'h1});
	endtask : t_lock
	task automatic t_misc;
		logic [15:0] z, w;
		for (int i = 0; i < 2; i++) begin
			z = 16'h4A6C | 16'(i);
			w = {1'b0, z[15:1]} ^ 16'h5A3C;
			run(OP_LPM, z, 16'h0, 1'b0);
			rd(REG_LPM, v);
			chk(v, 32'(z[0] ? w[15:8] : w[7:0]));
		end
		run(OP_LOAD, {9'h0, 6'd1, 1'b0}, 16'h0, 1'b1);
		rd(REG_STATUS, v);
		chk(32'({v[10], sp.spm_irq}), 32'h3);
		run(OP_LOAD, {9'h0, 6'd4, 1'b0}, 16'h0, 1'b0);
		chk(32'(sp.spm_irq), 32'h0);
		rd(8'h20, v);
		chk({v[29:0], resp}, {30'h0, RESP_SLVERR});
		wr(8'h24, 32'h1, RESP_SLVERR);
	endtask : t_misc
	// ========================================
	// verdict, main sequence and watchdog
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	initial begin
		t_boot();
		t_page();
		t_halt();
		t_discard();
		t_lock();
		t_misc();
		summarize();
	end
	// whole run needs well under a thousand cycles; this bound leaves ample margin
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		summarize();
	end
endmodule : tb_flash_self_programming_boot_entry
`default_nettype wire
